// file: pet_regs.vh
// Register offsets, field positions and reset values for the PWM
// event-trigger block. Assumes a plain word-addressed register port.
`ifndef PET_REGS_VH
`define PET_REGS_VH
// Register addresses
`define PET_ADDR_SELECT    4'h0
`define PET_ADDR_PRESCALE  4'h1
`define PET_ADDR_FLAGS     4'h2
`define PET_ADDR_MASK      4'h3
// Selection register fields
`define PET_SEL_IRQ_LSB    0
`define PET_SEL_IRQ_EN     3
`define PET_SEL_A_LSB      8
`define PET_SEL_A_EN       11
`define PET_SEL_B_LSB      12
`define PET_SEL_B_EN       15
// Prescale register fields
`define PET_PS_IRQ_PRD_LSB 0
`define PET_PS_IRQ_CNT_LSB 2
`define PET_PS_A_PRD_LSB   8
`define PET_PS_A_CNT_LSB   10
`define PET_PS_B_PRD_LSB   12
`define PET_PS_B_CNT_LSB   14
// Flag bits: 0 irq, 1 conv A, 2 conv B
`define PET_FLG_IRQ        0
`define PET_FLG_A          1
`define PET_FLG_B          2
// Event selector codes
`define PET_EV_ZERO        3'h1
`define PET_EV_PERIOD      3'h2
`define PET_EV_CA_UP       3'h4
`define PET_EV_CA_DN       3'h5
`define PET_EV_CB_UP       3'h6
`define PET_EV_CB_DN       3'h7
// Reset values
`define PET_RST_SELECT     16'h0000
`define PET_RST_PRESCALE   16'h0000
`define PET_RST_FLAGS      3'h0
`define PET_RST_MASK       3'h0
// One bit of a cleared event count, replicated to the counter width
`define PET_RST_CNT        1'b0
`endif

// file: pet_event_trigger.v
// Event-trigger logic: picks time-base events, prescales them into
// interrupt and two converter trigger pulses. Assumes event inputs are
// one-cycle strobes from logic on ref_clk_i.
`timescale 1ns/100ps
`include "pet_regs.vh"

module pet_event_trigger (
  input  wire        ref_clk_i,   // Time-base clock
  input  wire        srst_i,      // Sync reset, active high
  input  wire [3:0]  reg_addr_i,  // Register word address
  input  wire [15:0] reg_wdata_i, // Write data
  input  wire        reg_wr_i,    // Write strobe
  input  wire        reg_rd_i,    // Read strobe
  output reg  [15:0] reg_rdata_o, // Read data, one cycle later
  input  wire        ev_zero_i,   // Counter equals zero
  input  wire        ev_period_i, // Counter equals period
  input  wire        ev_compare_value_a_i,   // Counter equals compare A
  input  wire        ev_compare_value_b_i,   // Counter equals compare B
  input  wire        count_up_i,  // Time base incrementing
  output reg         module_irq_request_o,  // Level interrupt
  output reg         conv_a_trigger_pulse_o, // Conversion A pulse
  output reg         conv_b_trigger_pulse_o  // Conversion B pulse
);

  //////////////////////////////////////////////////////////////////////
  // Registers
  reg  [15:0] sel_q;      // event_trigger_select
  reg  [1:0]  irq_prd_q;  // Interrupt period
  reg  [1:0]  a_prd_q;    // conv_a_period
  reg  [1:0]  b_prd_q;    // conv_b_period
  reg  [1:0]  irq_cnt_q;  // irq_event_count
  reg  [2:0]  flags_q;    // event_trigger_flags, sticky
  reg  [2:0]  mask_q;     // Interrupt mask

  // Field views
  wire [2:0] irq_event_choice    = sel_q[`PET_SEL_IRQ_LSB +: 3];
  wire       irq_gen_enable      = sel_q[`PET_SEL_IRQ_EN];
  wire [2:0] conv_a_event_choice = sel_q[`PET_SEL_A_LSB +: 3];
  wire       conv_a_pulse_enable = sel_q[`PET_SEL_A_EN];
  wire [2:0] conv_b_event_choice = sel_q[`PET_SEL_B_LSB +: 3];
  wire       conv_b_pulse_enable = sel_q[`PET_SEL_B_EN];

  //////////////////////////////////////////////////////////////////////
  // Event selection: one decoder per consumer, since each selector
  // may name a different event in the same cycle
  wire irq_ev;  // Selected interrupt event
  wire a_ev;    // Selected conversion A event
  wire b_ev;    // Selected conversion B event

  // Interrupt event decoder
  pet_ev_pick pet_ev_pick_irq_inst (
    .code_i   (irq_event_choice),
    .zero_i   (ev_zero_i),
    .period_i (ev_period_i),
    .compare_value_a_i   (ev_compare_value_a_i),
    .compare_value_b_i   (ev_compare_value_b_i),
    .up_i     (count_up_i),
    .hit_o    (irq_ev)
  );

  // Conversion A event decoder
  pet_ev_pick pet_ev_pick_a_inst (
    .code_i   (conv_a_event_choice),
    .zero_i   (ev_zero_i),
    .period_i (ev_period_i),
    .compare_value_a_i   (ev_compare_value_a_i),
    .compare_value_b_i   (ev_compare_value_b_i),
    .up_i     (count_up_i),
    .hit_o    (a_ev)
  );

  // Conversion B event decoder
  pet_ev_pick pet_ev_pick_b_inst (
    .code_i   (conv_b_event_choice),
    .zero_i   (ev_zero_i),
    .period_i (ev_period_i),
    .compare_value_a_i   (ev_compare_value_a_i),
    .compare_value_b_i   (ev_compare_value_b_i),
    .up_i     (count_up_i),
    .hit_o    (b_ev)
  );

  //////////////////////////////////////////////////////////////////////
  // Conversion prescalers. The status flags are not wired in, so a
  // flag left set by an earlier trigger can never hold a pulse back.
  wire       a_fire;  // Conversion A qualifies this cycle
  wire       b_fire;  // Conversion B qualifies this cycle
  wire [1:0] a_cnt;   // conv_a_event_count
  wire [1:0] b_cnt;   // conv_b_event_count

  // Channel A counter
  pet_soc_chan #(
    .CNT_W (2)
  ) pet_soc_chan_a_inst (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .ev_i      (a_ev),
    .en_i      (conv_a_pulse_enable),
    .prd_i     (a_prd_q),
    .fire_o    (a_fire),
    .cnt_o     (a_cnt)
  );

  // Channel B counter
  pet_soc_chan #(
    .CNT_W (2)
  ) pet_soc_chan_b_inst (
    .ref_clk_i (ref_clk_i),
    .srst_i    (srst_i),
    .ev_i      (b_ev),
    .en_i      (conv_b_pulse_enable),
    .prd_i     (b_prd_q),
    .fire_o    (b_fire),
    .cnt_o     (b_cnt)
  );

  //////////////////////////////////////////////////////////////////////
  // Trigger pulses: registered, so each output comes from a flop and
  // lasts exactly one cycle after the qualifying event
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      conv_a_trigger_pulse_o <= 1'b0;
      conv_b_trigger_pulse_o <= 1'b0;
    end else begin
      // One-cycle pulses; flags never gate them
      conv_a_trigger_pulse_o <= a_fire;
      conv_b_trigger_pulse_o <= b_fire;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Interrupt prescale decisions
  // Blocked while generation is off or the last request is still set
  wire irq_block = ~irq_gen_enable | flags_q[`PET_FLG_IRQ];
  // Count parked at period while blocked
  wire irq_at    = (irq_prd_q != 2'h0) && (irq_cnt_q == irq_prd_q);
  // A parked count fires as soon as the block lifts, so events seen
  // while blocked delay the request rather than lose it
  wire irq_fire  = (irq_prd_q != 2'h0) && !irq_block &&
                   (irq_at || (irq_ev && (irq_cnt_q + 2'h1 == irq_prd_q)));

  //////////////////////////////////////////////////////////////////////
  // Interrupt counter
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      irq_cnt_q <= 2'h0;
    end else if (irq_prd_q == 2'h0) begin
      irq_cnt_q <= 2'h0;
    end else if (irq_fire) begin
      irq_cnt_q <= 2'h0;
    end else if (irq_ev && !irq_at) begin
      // Stops at period while blocked
      irq_cnt_q <= irq_cnt_q + 2'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Register writes, sticky flags (set beats write-one clear)
  wire wr_sel  = reg_wr_i && (reg_addr_i == `PET_ADDR_SELECT);
  wire wr_ps   = reg_wr_i && (reg_addr_i == `PET_ADDR_PRESCALE);
  wire wr_flg  = reg_wr_i && (reg_addr_i == `PET_ADDR_FLAGS);
  wire wr_mask = reg_wr_i && (reg_addr_i == `PET_ADDR_MASK);
  wire [2:0] flag_set = {b_fire, a_fire, irq_fire};
  wire [2:0] flag_clr = wr_flg ? reg_wdata_i[2:0] : 3'h0;

  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      sel_q     <= `PET_RST_SELECT;
      irq_prd_q <= 2'h0;
      a_prd_q   <= 2'h0;
      b_prd_q   <= 2'h0;
      flags_q   <= `PET_RST_FLAGS;
      mask_q    <= `PET_RST_MASK;
    end else begin
      if (wr_sel) begin
        // Bits 7:4 reserved, kept zero
        sel_q <= reg_wdata_i & 16'hff0f;
      end
      if (wr_ps) begin
        irq_prd_q <= reg_wdata_i[`PET_PS_IRQ_PRD_LSB +: 2];
        a_prd_q   <= reg_wdata_i[`PET_PS_A_PRD_LSB +: 2];
        b_prd_q   <= reg_wdata_i[`PET_PS_B_PRD_LSB +: 2];
      end
      if (wr_mask) begin
        mask_q <= reg_wdata_i[2:0];
      end
      flags_q <= (flags_q & ~flag_clr) | flag_set;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Interrupt output and read port
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      module_irq_request_o <= 1'b0;
      reg_rdata_o          <= 16'h0000;
    end else begin
      // Registered from the next flag value, so it changes on the same edge as status
      module_irq_request_o <= |(((flags_q & ~flag_clr) | flag_set) &
                                mask_q);
      if (reg_rd_i) begin
        case (reg_addr_i)
          `PET_ADDR_SELECT:   reg_rdata_o <= sel_q;
          `PET_ADDR_PRESCALE: reg_rdata_o <= {b_cnt, b_prd_q, a_cnt,
                                               a_prd_q, 4'h0, irq_cnt_q,
                                               irq_prd_q};
          `PET_ADDR_FLAGS:    reg_rdata_o <= {13'h0000, flags_q};
          `PET_ADDR_MASK:     reg_rdata_o <= {13'h0000, mask_q};
          default:            reg_rdata_o <= 16'h0000;
        endcase
      end else begin
        reg_rdata_o <= 16'h0000;
      end
    end
  end

endmodule // pet_event_trigger

////////////////////////////////////////////////////////////////////////
// Event decoder: maps a 3-bit selector onto the time-base strobes.
// Reserved codes decode to nothing, so a stray selector stays silent
// instead of borrowing a neighbouring event.
module pet_ev_pick (
  input  wire [2:0] code_i,    // Selector field
  input  wire       zero_i,    // Counter equals zero
  input  wire       period_i,  // Counter equals period
  input  wire       compare_value_a_i,    // Counter equals compare A
  input  wire       compare_value_b_i,    // Counter equals compare B
  input  wire       up_i,      // Time base incrementing
  output reg        hit_o      // Selected event this cycle
);

  // Plain decode; direction only matters for the compare matches.
  // A compare strobe seen at a turning point counts for one direction
  // only, whichever the time base reports in that cycle.
  always @* begin
    case (code_i)
      `PET_EV_ZERO:   hit_o = zero_i;
      `PET_EV_PERIOD: hit_o = period_i;
      `PET_EV_CA_UP:  hit_o = compare_value_a_i & up_i;
      `PET_EV_CA_DN:  hit_o = compare_value_a_i & ~up_i;
      `PET_EV_CB_UP:  hit_o = compare_value_b_i & up_i;
      `PET_EV_CB_DN:  hit_o = compare_value_b_i & ~up_i;
      default:        hit_o = 1'b0;
    endcase
  end

endmodule // pet_ev_pick

////////////////////////////////////////////////////////////////////////
// Conversion prescaler: counts selected events and says when the
// programmed number is reached. Period zero parks the count at zero.
// The fire output is combinational; the parent registers the pulse.
module pet_soc_chan #(
  parameter CNT_W = 2                  // Event count and period width
) (
  input  wire             ref_clk_i,   // Time-base clock
  input  wire             srst_i,      // Sync reset, active high
  input  wire             ev_i,        // Selected event this cycle
  input  wire             en_i,        // Pulse enable
  input  wire [CNT_W-1:0] prd_i,       // Events per pulse, 0 is off
  output wire             fire_o,      // Pulse qualifies this cycle
  output wire [CNT_W-1:0] cnt_o        // Events counted so far
);

  reg  [CNT_W-1:0] cnt_q;                               // Event count
  reg  [CNT_W-1:0] cnt_d;                               // Next count
  wire [CNT_W-1:0] zero_cnt = {CNT_W{`PET_RST_CNT}};    // Cleared count
  wire [CNT_W-1:0] nxt = cnt_q + {{(CNT_W-1){1'b0}}, ev_i};
  wire             live   = (prd_i != zero_cnt);        // Switched on
  wire             at_prd = (cnt_q == prd_i);           // Parked

  // A count parked at period while disabled fires on the next event
  // once enabled, rather than sticking there until the period field
  // is written again. Enable is only looked at when firing, so the
  // count still climbs to the period and stops there while the pulse is switched off.
  assign fire_o = live && en_i && ev_i &&
                  ((nxt == prd_i) || at_prd);
  assign cnt_o  = cnt_q;

  // Next count
  always @* begin
    cnt_d = cnt_q;                      // Hold by default
    if (!live) begin
      // Period off: counter idle and cleared
      cnt_d = zero_cnt;
    end else if (fire_o) begin
      // Cleared by the pulse itself, no software action
      cnt_d = zero_cnt;
    end else if (ev_i && !at_prd) begin
      // Disabled channel saturates at period rather than wrapping
      cnt_d = nxt;
    end
  end

  // Count register
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      cnt_q <= zero_cnt;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule // pet_soc_chan

// file: pet_chk_asserts.sv
// Port checker for the event-trigger block.
// Assumes register writes land one edge after the strobe.
`timescale 1ns/100ps
module pet_chk (
  input wire        ref_clk_i,
  input wire        srst_i,
  input wire [3:0]  reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire        reg_wr_i,
  input wire        reg_rd_i,
  input wire [15:0] reg_rdata_o,
  input wire        module_irq_request_o,
  input wire        conv_a_trigger_pulse_o,
  input wire        conv_b_trigger_pulse_o
);
  reg [15:0] sel_q; // Selection shadow
  reg [15:0] pre_q; // Prescale shadow
  reg [2:0]  msk_q; // Interrupt mask shadow
  // Shadows let gating be judged from the ports alone
  always @(posedge ref_clk_i) begin
    if (srst_i) begin
      sel_q <= 16'h0000;
      pre_q <= 16'h0000;
      msk_q <= 3'h0;
    end else if (reg_wr_i) begin
      if (reg_addr_i == 4'h0) sel_q <= reg_wdata_i;
      if (reg_addr_i == 4'h1) pre_q <= reg_wdata_i;
      if (reg_addr_i == 4'h3) msk_q <= reg_wdata_i[2:0];
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);
  AST_A_ONE: assert property (conv_a_trigger_pulse_o |=>
    !conv_a_trigger_pulse_o) else $error("conv A pulse too long");
  AST_B_ONE: assert property (conv_b_trigger_pulse_o |=>
    !conv_b_trigger_pulse_o) else $error("conv B pulse too long");
  AST_A_EN: assert property (conv_a_trigger_pulse_o |->
    $past(sel_q[11])) else $error("conv A pulse while disabled");
  AST_B_EN: assert property (conv_b_trigger_pulse_o |->
    $past(sel_q[15])) else $error("conv B pulse while disabled");
  AST_A_PRD: assert property (conv_a_trigger_pulse_o |->
    $past(pre_q[9:8]) != 2'h0) else $error("conv A pulse with period off");
  AST_B_PRD: assert property (conv_b_trigger_pulse_o |->
    $past(pre_q[13:12]) != 2'h0) else $error("conv B pulse, period off");
  AST_IRQ_MSK: assert property (module_irq_request_o |->
    $past(msk_q) != 3'h0) else $error("irq raised while masked");
  AST_RD_IDLE: assert property (!reg_rd_i |=>
    reg_rdata_o == 16'h0000) else $error("read data outside slot");
endmodule // pet_chk
bind pet_event_trigger pet_chk pet_chk_inst (
  .ref_clk_i(ref_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .module_irq_request_o(module_irq_request_o),
  .conv_a_trigger_pulse_o(conv_a_trigger_pulse_o),
  .conv_b_trigger_pulse_o(conv_b_trigger_pulse_o));

// file: pet_far_end.sv
// Converter trigger inputs: counts pulses of both channels.
// Assumes pulses are synchronous to ref_clk_i.
`timescale 1ns/100ps
module pet_far_end (
  input  wire        ref_clk_i,
  input  wire        conv_a_i,
  input  wire        conv_b_i,
  output reg  [31:0] n_a_o,
  output reg  [31:0] n_b_o
);
  initial n_a_o = 0;
  initial n_b_o = 0;
  // A level held over cycles counts each cycle, so long pulses show
  always @(posedge ref_clk_i) begin
    if (conv_a_i) n_a_o <= n_a_o + 1;
    if (conv_b_i) n_b_o <= n_b_o + 1;
  end
endmodule // pet_far_end

// file: tb_top.sv
// Testbench for the event-trigger block.
// Assumes one clock; the far end counts trigger pulses.
`timescale 1ns/100ps
module tb_top;
  reg ck = 0, rs = 1, wr = 0, rd = 0, up = 0;
  reg [3:0] ad = 0, ev = 0; // ev: zero, period, cmp A, cmp B
  reg [15:0] wd = 0;
  wire [15:0] rdat;
  wire irq, pa, pb;
  wire [31:0] na, nb;
  integer n_mismatch = 0, n_compared = 0, cyc = 0, c, i, e, a0, b0;
  always #2.5 ck = ~ck;
  pet_event_trigger pet_event_trigger_inst (.ref_clk_i(ck), .srst_i(rs),
    .reg_addr_i(ad), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdat), .ev_zero_i(ev[0]), .ev_period_i(ev[1]),
    .ev_compare_value_a_i(ev[2]), .ev_compare_value_b_i(ev[3]), .count_up_i(up),
    .module_irq_request_o(irq), .conv_a_trigger_pulse_o(pa),
    .conv_b_trigger_pulse_o(pb));
  pet_far_end pet_far_end_inst (.ref_clk_i(ck), .conv_a_i(pa),
    .conv_b_i(pb), .n_a_o(na), .n_b_o(nb));
  task chk(input [31:0] g, input [31:0] x);
    begin
      n_compared = n_compared + 1;
      if (g !== x) begin
        n_mismatch = n_mismatch + 1;
        $display("ERROR %0t got %h exp %h", $time, g, x);
      end
    end
  endtask
  task wrr(input [3:0] a, input [15:0] d);
    begin
      @(posedge ck) {ad, wd, wr} <= {a, d, 1'b1};
      @(posedge ck) wr <= 1'b0;
    end
  endtask
  task rdc(input [3:0] a, input [15:0] x);
    begin
      @(posedge ck) {ad, rd} <= {a, 1'b1};
      @(posedge ck) rd <= 1'b0;
      @(negedge ck) chk(rdat, x);
    end
  endtask
  // One-cycle event, then time for the pulse to land
  task fire(input [3:0] m, input u);
    begin
      @(posedge ck) {ev, up} <= {m, u};
      @(posedge ck) ev <= 4'h0;
      repeat (4) @(negedge ck);
    end
  endtask
  task final_report;
    begin
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (20) @(posedge ck);
    rs <= 1'b0;
    rdc(0, 0); rdc(1, 0); rdc(2, 0); rdc(3, 0); rdc(9, 0);
    wrr(9, 16'hffff); wrr(0, 16'hfff0); wrr(3, 16'hffff);
    rdc(0, 16'hff00); rdc(3, 16'h0007); rdc(9, 0);
    $display("registers done");
    wrr(1, 16'h1100);
    for (c = 0; c < 8; c = c + 1) begin
      wrr(0, {1'b1, c[2:0], 1'b1, c[2:0], 8'h00});
      for (i = 0; i < 6; i = i + 1) begin
        a0 = na;
        b0 = nb;
        e = (c == (i < 2 ? i + 1 : i + 2));
        fire(i < 2 ? 4'h1 << i : (i < 4 ? 4'h4 : 4'h8), ~i[0]);
        chk(na - a0, e);
        chk(nb - b0, e);
      end
    end
    $display("selectors done");
    wrr(0, 16'h9900); wrr(1, 16'h3200);
    a0 = na;
    b0 = nb;
    fire(1, 0); rdc(1, 16'h7600);
    fire(1, 0); rdc(1, 16'hb200);
    chk(na - a0, 1);
    fire(1, 0); rdc(1, 16'h3600);
    chk(nb - b0, 1);
    wrr(0, 16'h1100); wrr(1, 16'h1100);
    fire(1, 0); fire(1, 0); rdc(1, 16'h5500);
    chk(na - a0, 1);
    chk(nb - b0, 1);
    wrr(0, 16'h9900); fire(1, 0); rdc(1, 16'h1100);
    wrr(1, 0);
    fire(1, 0); rdc(1, 0);
    chk(na - a0, 2);
    chk(nb - b0, 2);
    $display("prescale done");
    wrr(2, 16'h0007); rdc(2, 0);
    wrr(3, 1); wrr(0, 16'h0009); wrr(1, 16'h0002);
    fire(1, 0); rdc(1, 16'h0006); chk(irq, 0);
    fire(1, 0); chk(irq, 1);
    rdc(1, 16'h0002);
    rdc(2, 1); wrr(2, 1); rdc(2, 0);
    chk(irq, 0);
    wrr(0, 16'h0001); fire(1, 0); fire(1, 0); fire(1, 0);
    rdc(1, 16'h000a); rdc(2, 0);
    wrr(0, 16'h0009); rdc(2, 1); chk(irq, 1);
    rdc(1, 16'h0002);
    $display("interrupt done");
    final_report;
  end
  // Run is well under a thousand cycles
  always @(posedge ck) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      n_mismatch = n_mismatch + 1;
      final_report;
    end
  end
endmodule // tb_top
